// >>> common/sprs_pkg.sv
// Shared constants and types for the push, relative-call and software-reset executor
package sprs_pkg;
  localparam int INSTR_W = 16;
  localparam int PC_W = 21;
  localparam int OFFS_W = 11;
  localparam int NUM_PHASES = 4;
  localparam logic [15:0] OPC_PUSH = 16'h0005;
  localparam logic [15:0] OPC_SOFT_RESET = 16'h00ff;
  localparam logic [4:0] OPC_RELATIVE_CALL_INSTR_HI = 5'h1b;
  localparam int RELATIVE_CALL_INSTR_HI_POS = 11;
  localparam logic [20:0] RESET_VECTOR = 21'h000000;
  localparam logic [20:0] PC_STEP = 21'h000002;
  localparam logic [1:0] PHASE_Q1 = 2'h0;
  localparam logic [1:0] PHASE_Q2 = 2'h1;
  localparam logic [1:0] PHASE_Q4 = 2'h3;
  localparam logic [1:0] PHASE_RST = 2'h0;
  typedef enum logic [1:0] {SPRS_FETCH, SPRS_FLUSH, SPRS_SRESET} sprs_state_t;
endpackage

// >>> rtl/sprs_phase_gen.sv
// Four-phase instruction cycle generator
module sprs_phase_gen
  import sprs_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  input wire logic sw_rst,
  // Phase
  output logic [1:0] phase,
  output logic cycle_end
);
  logic [1:0] phase_ff;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      phase_ff <= PHASE_RST;
    else if (sw_rst)
      phase_ff <= PHASE_RST;
    else
      phase_ff <= phase_ff + 2'h1;
  end

  assign phase = phase_ff;
  assign cycle_end = (phase_ff == PHASE_Q4);
endmodule

// >>> rtl/sprs_exec.sv
// Execution of push, relative call and software reset
module sprs_exec
  import sprs_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Decoded instruction
  input wire logic instr_valid,
  input wire logic [sprs_pkg::INSTR_W-1:0] instr,
  // Program counter
  output logic [sprs_pkg::PC_W-1:0] pc,
  output logic pc_load,
  // Return stack
  output logic stack_push,
  output logic [sprs_pkg::PC_W-1:0] top_of_return_stack,
  // Status
  output logic flag_write,
  output logic pipe_flush,
  output logic master_clear_reset,
  output logic [1:0] phase
);
  sprs_state_t state_ff;
  logic [PC_W-1:0] pc_ff;
  logic [PC_W-1:0] tos_ff;
  logic push_ff;
  logic load_ff;
  logic flush_ff;
  logic swrst_ff;
  logic refill_ff;
  logic flag_ff;
  logic [1:0] ph;
  logic cyc_end;
  logic is_push;
  logic is_relative_call_instr;
  logic is_sreset;
  logic take;
  logic [PC_W-1:0] ret_addr;
  logic [PC_W-1:0] nxt_target;
  logic [PC_W-1:0] offs2;

  sprs_phase_gen u_phase
  (
    .clock(clock),
    .rst(rst),
    .sw_rst(swrst_ff),
    .phase(ph),
    .cycle_end(cyc_end)
  );

  // Only a fetch cycle decodes; the refill cycle ignores whatever was prefetched
  assign take = instr_valid && (state_ff == SPRS_FETCH) && (ph == PHASE_Q2);
  assign is_push = (instr == OPC_PUSH);
  assign is_relative_call_instr = (instr[INSTR_W-1:RELATIVE_CALL_INSTR_HI_POS] == OPC_RELATIVE_CALL_INSTR_HI);
  assign is_sreset = (instr == OPC_SOFT_RESET);
  assign ret_addr = pc_ff + PC_STEP;
  // Word offset doubled and sign extended to PC width
  assign offs2 = {{(PC_W-OFFS_W-1){instr[OFFS_W-1]}}, instr[OFFS_W-1:0], 1'b0};
  assign nxt_target = ret_addr + offs2;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      state_ff <= SPRS_FETCH;
    else if (swrst_ff)
      state_ff <= SPRS_FETCH;
    else if (take && is_sreset)
      state_ff <= SPRS_SRESET;
    else if (take && is_relative_call_instr)
      state_ff <= SPRS_FLUSH;
    else if (cyc_end && state_ff == SPRS_FLUSH && refill_ff)
      state_ff <= SPRS_FETCH;
  end

  // Counts the Q4 edges spent in refill; the first ends the call's own cycle,
  // the second ends the dead cycle, so a prefetched word is never executed
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      refill_ff <= 1'b0;
    else if (swrst_ff)
      refill_ff <= 1'b0;
    else if (take && is_relative_call_instr)
      refill_ff <= 1'b0;
    else if (cyc_end && state_ff == SPRS_FLUSH)
      refill_ff <= !refill_ff;
  end

  // Program counter; pushes read the old value so the push precedes the jump
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      pc_ff <= RESET_VECTOR;
    else if (swrst_ff)
      pc_ff <= RESET_VECTOR;
    else if (take && is_relative_call_instr)
      pc_ff <= nxt_target;
    // Sequential advance; held through a call and its refill cycle
    else if (cyc_end && state_ff == SPRS_FETCH && !load_ff)
      pc_ff <= ret_addr;
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      tos_ff <= RESET_VECTOR;
    else if (swrst_ff)
      tos_ff <= RESET_VECTOR;
    else if (take && (is_push || is_relative_call_instr))
      tos_ff <= ret_addr;
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      push_ff <= 1'b0;
      load_ff <= 1'b0;
      flush_ff <= 1'b0;
      swrst_ff <= 1'b0;
    end
    else
    begin
      push_ff <= take && (is_push || is_relative_call_instr);
      load_ff <= (take && is_relative_call_instr) || swrst_ff;
      flush_ff <= take && is_relative_call_instr;
      swrst_ff <= take && is_sreset;
    end
  end

  // Kept as a register so every output leaves from a flip-flop
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      flag_ff <= 1'b0;
    else
      flag_ff <= 1'b0;
  end

  assign pc = pc_ff;
  assign pc_load = load_ff;
  assign stack_push = push_ff;
  assign top_of_return_stack = tos_ff;
  // None of these instructions writes status; reset clears via master_clear_reset
  assign flag_write = flag_ff;
  assign pipe_flush = flush_ff;
  assign master_clear_reset = swrst_ff;
  assign phase = ph;

  // Push: answers appear one edge after the phase-two take
  AST_PUSH_TOS: assert property (@(posedge clock) disable iff (rst)
    take && is_push |=> stack_push && top_of_return_stack == $past(pc_ff) + PC_STEP)
    else $error("push top of stack wrong");
  AST_STACK_PULSE: assert property (@(posedge clock) disable iff (rst)
    stack_push |=> !stack_push)
    else $error("stack push longer than one cycle");
  AST_TOS_CAUSE: assert property (@(posedge clock) disable iff (rst)
    $changed(top_of_return_stack) |-> stack_push || pc_load)
    else $error("top of stack changed without a push");
  AST_PUSH_ONE_CYCLE: assert property (@(posedge clock) disable iff (rst)
    take && is_push |=> state_ff == SPRS_FETCH && !pipe_flush)
    else $error("push not single cycle");
  AST_PUSH_NO_LOAD: assert property (@(posedge clock) disable iff (rst)
    take && is_push |=> !pc_load && pc == $past(pc))
    else $error("push moved the program counter");
  AST_PC_STEP: assert property (@(posedge clock) disable iff (rst)
    $changed(pc) |-> pc_load || pc == $past(pc) + PC_STEP)
    else $error("program counter moved by a wrong step");
  AST_NO_FLAGS: assert property (@(posedge clock) disable iff (rst)
    take && (is_push || is_relative_call_instr) |=> !flag_write)
    else $error("flags touched");

  // Relative call: push and jump on one edge, then a whole dead cycle
  AST_RELATIVE_CALL_INSTR_SIGN: assert property (@(posedge clock) disable iff (rst)
    take && is_relative_call_instr |-> !offs2[0] && offs2[PC_W-1:OFFS_W] == {(PC_W-OFFS_W){instr[OFFS_W-1]}})
    else $error("offset sign extension wrong");
  AST_RELATIVE_CALL_INSTR_RET: assert property (@(posedge clock) disable iff (rst)
    take && is_relative_call_instr |=> top_of_return_stack == $past(ret_addr) && stack_push)
    else $error("relative call return address wrong");
  AST_RELATIVE_CALL_INSTR_PC: assert property (@(posedge clock) disable iff (rst)
    take && is_relative_call_instr |=> pc == $past(nxt_target) && pc_load)
    else $error("relative call target wrong");
  AST_RELATIVE_CALL_INSTR_FLUSH: assert property (@(posedge clock) disable iff (rst)
    take && is_relative_call_instr |=> (state_ff == SPRS_FLUSH) [*6] ##1 state_ff == SPRS_FETCH)
    else $error("relative call refill cycle wrong");
  AST_FLUSH_CAUSE: assert property (@(posedge clock) disable iff (rst)
    pipe_flush |-> pc_load && stack_push)
    else $error("flush without a relative call");
  AST_REFILL_IDLE: assert property (@(posedge clock) disable iff (rst)
    pipe_flush |=> (!stack_push && !pc_load) [*7])
    else $error("instruction taken during refill");
  AST_REFILL_PC: assert property (@(posedge clock) disable iff (rst)
    state_ff == SPRS_FLUSH |=> $stable(pc))
    else $error("program counter moved during refill");

  // Software reset: one-cycle request, local state cleared on the next edge
  AST_SRESET_PULSE: assert property (@(posedge clock) disable iff (rst)
    take && is_sreset |=> master_clear_reset ##1 !master_clear_reset)
    else $error("software reset pulse wrong");
  AST_SRESET_PHASE: assert property (@(posedge clock) disable iff (rst)
    master_clear_reset |-> $past(ph) == PHASE_Q2)
    else $error("software reset not started in phase two");
  AST_SRESET_QUIET: assert property (@(posedge clock) disable iff (rst)
    take && is_sreset |=> !stack_push && !pipe_flush)
    else $error("software reset pushed or flushed");
  AST_SRESET_STATE: assert property (@(posedge clock) disable iff (rst)
    master_clear_reset |=> pc == RESET_VECTOR && top_of_return_stack == RESET_VECTOR && phase == PHASE_Q1)
    else $error("software reset values wrong");
  AST_SRESET_FETCH: assert property (@(posedge clock) disable iff (rst)
    master_clear_reset |=> state_ff == SPRS_FETCH)
    else $error("fetch not resumed");

  CV_PUSH: cover property (@(posedge clock) disable iff (rst) take && is_push);
  CV_RELATIVE_CALL_INSTR_NEG: cover property (@(posedge clock) disable iff (rst) take && is_relative_call_instr && instr[OFFS_W-1]);
  CV_RELATIVE_CALL_INSTR_POS: cover property (@(posedge clock) disable iff (rst) take && is_relative_call_instr && !instr[OFFS_W-1]);
  CV_REFILL_DROP: cover property (@(posedge clock) disable iff (rst) state_ff == SPRS_FLUSH && instr_valid && ph == PHASE_Q2);
  CV_SRESET: cover property (@(posedge clock) disable iff (rst) master_clear_reset);
endmodule

// >>> test/tb.sv
// Self-checking bench for the push, relative-call and software-reset executor
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import sprs_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic instr_valid = 1'b0;
  logic [INSTR_W-1:0] instr = 16'h0000;
  logic [PC_W-1:0] pc, top_of_return_stack, pc0, ret0;
  logic pc_load, stack_push, flag_write, pipe_flush, master_clear_reset;
  logic [1:0] phase;
  logic [OFFS_W-1:0] offs;
  int failures = 0;
  int check_count = 0;
  int cycles = 0;
  sprs_exec u_sprs_exec (.clock(clock), .rst(rst), .instr_valid(instr_valid), .instr(instr), .pc(pc),
    .pc_load(pc_load), .stack_push(stack_push), .top_of_return_stack(top_of_return_stack),
    .flag_write(flag_write), .pipe_flush(pipe_flush), .master_clear_reset(master_clear_reset), .phase(phase));
  always #2.5 clock = ~clock;
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      finish_test();
    end
  end
  // Word offset: target moves in two-byte steps
  function automatic logic [PC_W-1:0] f_target(input logic [PC_W-1:0] p, input logic [OFFS_W-1:0] n);
    return p + PC_STEP + {{(PC_W-OFFS_W-1){n[OFFS_W-1]}}, n, 1'b0};
  endfunction
  task automatic check(input string what, input logic [PC_W-1:0] seen, input logic [PC_W-1:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Opcode set up one edge before the phase-two take edge
  task automatic issue(input logic [INSTR_W-1:0] op, output logic [PC_W-1:0] p);
    @(posedge clock);
    while (phase !== PHASE_Q1)
      @(posedge clock);
    instr <= op;
    instr_valid <= 1'b1;
    p = pc;
    @(posedge clock);
    instr_valid <= 1'b0;
    instr <= 16'($urandom());
    #1;
  endtask
  task automatic finish_test();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    void'($urandom(43));
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    repeat (6)
    begin
      issue(OPC_PUSH, pc0);
      check("push_strobes", 21'({stack_push, pc_load, pipe_flush, flag_write}), 21'h8);
      check("push_tos", top_of_return_stack, pc0 + PC_STEP);
      @(posedge clock);
      #1;
      check("push_pulse", 21'(stack_push), 21'h0);
    end
    issue(16'h0006, pc0);
    check("unknown_op", 21'({stack_push, pc_load, master_clear_reset}), 21'h0);
    $display("push test done");
    for (int i = 0; i < 10; i++)
    begin
      offs = (i == 0) ? 11'h400 : (i == 1) ? 11'h3ff : 11'($urandom());
      issue({OPC_RELATIVE_CALL_INSTR_HI, offs}, pc0);
      ret0 = pc0 + PC_STEP;
      check("relative_call_instr_pc", pc, f_target(pc0, offs));
      check("relative_call_instr_tos", top_of_return_stack, pc0 + PC_STEP);
      check("relative_call_instr_strobes", 21'({stack_push, pc_load, pipe_flush, flag_write}), 21'he);
      // Second cycle is a refill no-op, so this push must be dropped
      issue(OPC_PUSH, pc0);
      check("refill_push", 21'(stack_push), 21'h0);
      check("refill_tos", top_of_return_stack, ret0);
      check("refill_pc", pc0, f_target(ret0 - PC_STEP, offs));
    end
    $display("relative call test done");
    repeat (2)
    begin
      issue(OPC_SOFT_RESET, pc0);
      check("sreset_pulse", 21'({master_clear_reset, stack_push, flag_write}), 21'h4);
      @(posedge clock);
      #1;
      check("sreset_pc", pc, RESET_VECTOR);
      check("sreset_tos", top_of_return_stack, 21'h0);
      check("sreset_phase", 21'(phase), 21'(PHASE_RST));
      check("sreset_load", 21'(pc_load), 21'h1);
      issue(OPC_PUSH, pc0);
      check("after_sreset", top_of_return_stack, RESET_VECTOR + PC_STEP);
    end
    $display("software reset test done");
    finish_test();
  end
endmodule
